// File: design/gpe_cfg.svh
// Offsets, field positions, reset values and sizes of the general purpose event unit.
// Assumes a 12-bit APB byte address space with one aligned 32-bit word per register.
`ifndef GPE_CFG_SVH
`define GPE_CFG_SVH

`define GPE_ADDR_W        12
`define GPE_NPORTS        4

`define GPE_CTL_OFF       12'h35c
`define GPE_STS_OFF       12'h360
`define GPE_INT_STS_OFF   12'h364
`define GPE_INT_MASK_OFF  12'h368
`define GPE_PIN_CTL_OFF   12'h36c

`define GPE_CTL_INV_BIT   0
`define GPE_CTL_EN_LSB    2
`define GPE_CTL_EN_MSB    5
`define GPE_STS_LSB       1
`define GPE_STS_MSB       4

`define GPE_PIN_ALT_BIT   0
`define GPE_PIN_OUT_BIT   1
`define GPE_PIN_OE_BIT    2
`define GPE_PIN_LVL_BIT   3

`define GPE_CTL_RST       32'h00000000
`define GPE_MASK_RST      4'h0
`define GPE_PIN_RST       3'h0

`endif

// File: design/gpe_pkg.sv
// Types shared by the general purpose event unit: APB carriers, pin carrier, bus phase.
// Assumes the constants of gpe_cfg.svh for the address width.
`include "gpe_cfg.svh"

package gpe_pkg;

    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`GPE_ADDR_W-1:0] paddr;
        logic [31:0]            pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic o;
        logic oe;
    } pin_drv_t;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SETUP  = 2'b01,
        PH_ACCESS = 2'b10
    } apb_phase_t;

endpackage

// File: design/gpe_sync3.sv
// Three-flop input synchroniser; the output follows once the last two stages agree.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/100ps

module gpe_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q_r
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A single glitchy sample never reaches the output
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q_r <= '0;
        end else if (s2_r == s3_r) begin
            q_r <= s3_r;
        end
    end

endmodule

// File: design/gpe_port_cell.sv
// One downstream port's event path: gating by its enable and in-band suppression.
// Assumes hp_req is a level from hot-plug logic on the mclk domain.
`timescale 1ns/100ps

module gpe_port_cell (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // Port side
    input  wire logic hp_req,
    input  wire logic event_en,
    output logic      inband_en,
    // Event side
    output logic      active_r,
    output logic      rise
);

    logic active_nxt;

    assign active_nxt = hp_req & event_en;
    assign inband_en  = ~event_en;
    assign rise       = active_nxt & ~active_r;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            active_r <= 1'b0;
        end else begin
            active_r <= active_nxt;
        end
    end

endmodule

// File: design/general_purpose_event_unit.sv
// General purpose event unit: hot-plug events of ports 2 to 5 on one shared event pin.
// Assumes an APB master on mclk, hot-plug request levels on mclk and an asynchronous pin.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "gpe_cfg.svh"

module general_purpose_event_unit (
    // Clock and reset
    input  wire logic                            mclk,
    input  wire logic                            rstn,
    input  wire logic                            warm_rst,
    // APB slave
    input  wire gpe_pkg::apb_req_t               apb_req,
    output gpe_pkg::apb_rsp_t                    apb_rsp,
    // Port hot-plug events, ports 2 to 5 on bits 0 to 3
    input  wire logic [`GPE_NPORTS-1:0]          hp_event_req,
    output logic      [`GPE_NPORTS-1:0]          inband_notify_en,
    // Shared event, active high inside the core
    output logic                                 shared_event_out,
    // General purpose pin 7
    input  wire logic                            gpio7_i,
    output gpe_pkg::pin_drv_t                    gpio7_drv,
    // Interrupt
    output logic                                 irq
);

    gpe_pkg::apb_phase_t phase_r;
    gpe_pkg::apb_phase_t phase_nxt;

    logic                   setup;
    logic                   access;
    logic                   wr_en;
    logic                   rd_done;
    logic [`GPE_ADDR_W-1:0] addr;
    logic                   hit_ctl;
    logic                   hit_sts;
    logic                   hit_int;
    logic                   hit_mask;
    logic                   hit_pin;
    logic                   hit_any;
    logic                   in_access;

    logic [31:0]            ctl_r;
    logic [31:0]            ctl_nxt;
    logic                   invert;
    logic [`GPE_NPORTS-1:0] port_en;

    logic [2:0]             pin_ctl_r;
    logic                   alt_sel;
    logic                   pin_lvl;

    logic [`GPE_NPORTS-1:0] active;
    logic [`GPE_NPORTS-1:0] rise;
    logic                   any_active;
    logic                   event_level;

    logic [`GPE_NPORTS-1:0] int_sts_r;
    logic [`GPE_NPORTS-1:0] int_sts_nxt;
    logic [`GPE_NPORTS-1:0] int_clr_r;
    logic [`GPE_NPORTS-1:0] mask_r;
    logic                   irq_r;

    logic [31:0]            rd_data;
    logic [31:0]            prdata_r;
    logic [31:0]            prdata_nxt;
    logic                   slverr_r;

    logic                   shared_r;
    logic                   pin_o_r;
    logic                   pin_oe_r;
    logic                   pin_o_nxt;
    logic                   pin_oe_nxt;

    // Bus phase tracking

    assign setup  = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;
    assign addr   = apb_req.paddr;

    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            gpe_pkg::PH_IDLE: begin
                if (setup) begin
                    phase_nxt = gpe_pkg::PH_SETUP;
                end
            end
            gpe_pkg::PH_SETUP: begin
                phase_nxt = gpe_pkg::PH_ACCESS;
            end
            gpe_pkg::PH_ACCESS: begin
                if (setup) begin
                    phase_nxt = gpe_pkg::PH_SETUP;
                end else begin
                    phase_nxt = gpe_pkg::PH_IDLE;
                end
            end
            default: begin
                phase_nxt = gpe_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= gpe_pkg::PH_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // An access counts only after its own setup cycle, when the decode flops are fresh
    assign in_access = access & (phase_r == gpe_pkg::PH_SETUP);

    // Zero wait states: every access phase completes at its first edge
    assign apb_rsp.pready  = access;
    assign apb_rsp.prdata  = prdata_r;
    assign apb_rsp.pslverr = slverr_r & access;

    // Address decode; misaligned addresses fall into the unmapped set

    always_comb begin
        hit_ctl  = 1'b0;
        hit_sts  = 1'b0;
        hit_int  = 1'b0;
        hit_mask = 1'b0;
        hit_pin  = 1'b0;
        case (addr)
            `GPE_CTL_OFF: begin
                hit_ctl = 1'b1;
            end
            `GPE_STS_OFF: begin
                hit_sts = 1'b1;
            end
            `GPE_INT_STS_OFF: begin
                hit_int = 1'b1;
            end
            `GPE_INT_MASK_OFF: begin
                hit_mask = 1'b1;
            end
            `GPE_PIN_CTL_OFF: begin
                hit_pin = 1'b1;
            end
            default: begin
                hit_ctl = 1'b0;
            end
        endcase
    end

    assign hit_any = hit_ctl | hit_sts | hit_int | hit_mask | hit_pin;

    assign wr_en   = in_access & apb_req.pwrite & ~slverr_r;
    assign rd_done = in_access & ~apb_req.pwrite & ~slverr_r;

    // Event control: survives warm reset, cleared only by rstn

    // Reserved bits are dropped on write so they always read back as zero
    always_comb begin
        ctl_nxt = 32'h00000000;
        ctl_nxt[`GPE_CTL_INV_BIT] = apb_req.pwdata[`GPE_CTL_INV_BIT];
        ctl_nxt[`GPE_CTL_EN_MSB:`GPE_CTL_EN_LSB] =
            apb_req.pwdata[`GPE_CTL_EN_MSB:`GPE_CTL_EN_LSB];
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= `GPE_CTL_RST;
        end else if (wr_en && hit_ctl) begin
            ctl_r <= ctl_nxt;
        end
    end

    assign invert  = ctl_r[`GPE_CTL_INV_BIT];
    assign port_en = ctl_r[`GPE_CTL_EN_MSB:`GPE_CTL_EN_LSB];

    // Pin 7 function select and plain GPIO drive

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_ctl_r <= `GPE_PIN_RST;
        end else if (warm_rst) begin
            pin_ctl_r <= `GPE_PIN_RST;
        end else if (wr_en && hit_pin) begin
            pin_ctl_r <= apb_req.pwdata[`GPE_PIN_OE_BIT:`GPE_PIN_ALT_BIT];
        end
    end

    assign alt_sel = pin_ctl_r[`GPE_PIN_ALT_BIT];

    // The pad is asynchronous, so its level is read back only through the synchroniser
    gpe_sync3 #(
        .W (1)
    ) u_pin_sync (
        .mclk (mclk),
        .rstn (rstn),
        .d    (gpio7_i),
        .q_r  (pin_lvl)
    );

    // Per-port event cells

    genvar gi;
    generate
        for (gi = 0; gi < `GPE_NPORTS; gi = gi + 1) begin : g_port
            gpe_port_cell u_cell (
                .mclk      (mclk),
                .rstn      (rstn),
                .hp_req    (hp_event_req[gi]),
                .event_en  (port_en[gi]),
                .inband_en (inband_notify_en[gi]),
                .active_r  (active[gi]),
                .rise      (rise[gi])
            );
        end
    endgenerate

    assign any_active  = |active;
    assign event_level = invert ? any_active : ~any_active;

    // Sticky interrupt status; a new event wins over a clear-on-read

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            int_clr_r <= '0;
        end else if (setup && hit_int && !apb_req.pwrite) begin
            int_clr_r <= int_sts_r;
        end
    end

    always_comb begin
        int_sts_nxt = int_sts_r | rise;
        if (rd_done && hit_int) begin
            int_sts_nxt = (int_sts_r & ~int_clr_r) | rise;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            int_sts_r <= '0;
        end else if (warm_rst) begin
            int_sts_r <= '0;
        end else begin
            int_sts_r <= int_sts_nxt;
        end
    end

    // Same bit layout as the status register, so software can reuse one pattern
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= `GPE_MASK_RST;
        end else if (warm_rst) begin
            mask_r <= `GPE_MASK_RST;
        end else if (wr_en && hit_mask) begin
            mask_r <= apb_req.pwdata[`GPE_STS_MSB:`GPE_STS_LSB];
        end
    end

    // Registered so the interrupt cannot glitch while status and mask change together
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_sts_r & mask_r);
        end
    end

    assign irq = irq_r;

    // Read data mux; reserved bits read as zero

    always_comb begin
        rd_data = 32'h00000000;
        if (hit_ctl) begin
            rd_data = ctl_r;
        end else if (hit_sts) begin
            rd_data[`GPE_STS_MSB:`GPE_STS_LSB] = active;
        end else if (hit_int) begin
            rd_data[`GPE_STS_MSB:`GPE_STS_LSB] = int_sts_r;
        end else if (hit_mask) begin
            rd_data[`GPE_STS_MSB:`GPE_STS_LSB] = mask_r;
        end else if (hit_pin) begin
            rd_data[`GPE_PIN_OE_BIT:`GPE_PIN_ALT_BIT] = pin_ctl_r;
            rd_data[`GPE_PIN_LVL_BIT] = pin_lvl;
        end
    end

    // Write cycles return zero data
    always_comb begin
        prdata_nxt = rd_data;
        if (apb_req.pwrite) begin
            prdata_nxt = 32'h00000000;
        end
    end

    // Data and error are caught in the setup cycle so they come from flops in access
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= 32'h00000000;
            slverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= prdata_nxt;
            slverr_r <= ~hit_any;
        end
    end

    // Shared event and pin 7 drive

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shared_r <= 1'b0;
        end else begin
            shared_r <= any_active;
        end
    end

    assign shared_event_out = shared_r;

    always_comb begin
        if (alt_sel) begin
            pin_o_nxt  = event_level;
            pin_oe_nxt = 1'b1;
        end else begin
            pin_o_nxt  = pin_ctl_r[`GPE_PIN_OUT_BIT];
            pin_oe_nxt = pin_ctl_r[`GPE_PIN_OE_BIT];
        end
    end

    // Inactive level of active-low signalling is high, so reset parks the pin released
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_o_r  <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            pin_o_r  <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign gpio7_drv.o  = pin_o_r;
    assign gpio7_drv.oe = pin_oe_r;

endmodule

// File: verif/gpe_checker.sv
// Port checker of the general purpose event unit, bound to its top module.
// Assumes software never writes in the same cycle as a warm reset.
`timescale 1ns/100ps
module gpe_checker (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rstn,
    input wire logic              warm_rst,
    // Bus
    input wire gpe_pkg::apb_req_t apb_req,
    input wire gpe_pkg::apb_rsp_t apb_rsp,
    // Events and pin
    input wire logic [3:0]        hp_event_req,
    input wire logic [3:0]        inband_notify_en,
    input wire logic              shared_event_out,
    input wire logic              gpio7_i,
    input wire gpe_pkg::pin_drv_t gpio7_drv,
    input wire logic              irq
);
    logic [5:0] ctl_r;
    logic [2:0] pin_r;
    logic [3:0] msk_r;
    logic       acc;
    logic       wr;
    logic       rd;
    assign acc = apb_req.psel & apb_req.penable;
    assign wr  = acc & apb_req.pwrite;
    assign rd  = acc & ~apb_req.pwrite;
    // Mirrors of what software set, so outputs can be tied to it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= 6'h00;
        end else if (wr && apb_req.paddr == 12'h35c) begin
            ctl_r <= apb_req.pwdata[5:0] & 6'h3d;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_r <= 3'h0;
            msk_r <= 4'h0;
        end else if (warm_rst) begin
            pin_r <= 3'h0;
            msk_r <= 4'h0;
        end else if (wr && apb_req.paddr == 12'h36c) begin
            pin_r <= apb_req.pwdata[2:0];
        end else if (wr && apb_req.paddr == 12'h368) begin
            msk_r <= apb_req.pwdata[4:1];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    AST_INBAND: assert property (inband_notify_en == ~ctl_r[5:2])
        else $error("in-band enable does not follow the port enables");
    AST_SHARED: assert property (shared_event_out == $past(|(hp_event_req & ctl_r[5:2]), 2))
        else $error("shared event is not the OR of enabled events");
    AST_PIN_ALT: assert property ($past(pin_r[0]) |-> gpio7_drv.oe &&
        gpio7_drv.o == ($past(ctl_r[0]) ~^ shared_event_out))
        else $error("pin 7 level wrong in alternate mode");
    AST_PIN_GPIO: assert property (!$past(pin_r[0]) |-> gpio7_drv.o == $past(pin_r[1]) &&
        gpio7_drv.oe == $past(pin_r[2]))
        else $error("event leaked onto pin 7 in plain mode");
    AST_PREADY: assert property (apb_rsp.pready == acc)
        else $error("pready not zero wait");
    AST_SLVERR: assert property (acc |-> apb_rsp.pslverr ==
        !(apb_req.paddr inside {12'h35c, 12'h360, 12'h364, 12'h368, 12'h36c}))
        else $error("pslverr wrong for address");
    AST_STS_RD: assert property (rd && apb_req.paddr == 12'h360 |-> apb_rsp.prdata ==
        {27'h0, $past(hp_event_req & ctl_r[5:2], 2), 1'b0})
        else $error("event status read wrong");
    AST_CTL_RD: assert property (rd && apb_req.paddr == 12'h35c |->
        apb_rsp.prdata == {26'h0, $past(ctl_r)})
        else $error("event control read wrong");
    AST_IRQ: assert property (irq |-> $past(msk_r) != 4'h0)
        else $error("interrupt raised while fully masked");
    cover property ($rose(shared_event_out));
    cover property ($past(pin_r[0]) && gpio7_drv.o);
    cover property ($rose(irq));
endmodule

bind general_purpose_event_unit gpe_checker u_chk (.mclk(mclk), .rstn(rstn),
    .warm_rst(warm_rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .irq(irq),
    .hp_event_req(hp_event_req), .inband_notify_en(inband_notify_en),
    .shared_event_out(shared_event_out), .gpio7_i(gpio7_i), .gpio7_drv(gpio7_drv));

// File: verif/gpe_pin_host.sv
// System logic watching pin 7, decoding the event in the chosen polarity.
// Assumes no pull on the pin: released, it shows the inverse of its last level.
`timescale 1ns/100ps
module gpe_pin_host (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rstn,
    // Pin
    input wire gpe_pkg::pin_drv_t drv,
    input wire logic              inv,
    output logic                  pin,
    output logic                  evt
);
    logic last_r;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            last_r <= 1'b0;
        end else if (drv.oe) begin
            last_r <= drv.o;
        end
    end
    // Released, the pin flips away from its last driven level, so stale drive never looks valid
    assign pin = drv.oe ? drv.o : ~last_r;
    assign evt = drv.oe & (inv ? pin : ~pin);
endmodule

// File: verif/testbench.sv
// Self-checking bench of the event unit driven over APB.
// Assumes zero-wait APB and a two-edge event latency.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
    logic              mclk, rstn, warm_rst, irq, shr, pin, evt, inv, err;
    gpe_pkg::apb_req_t req;
    gpe_pkg::apb_rsp_t rsp;
    gpe_pkg::pin_drv_t drv;
    logic [3:0]        hp, ibn;
    logic [31:0]       rd;
    logic [11:0]       adr [5] = '{12'h35c, 12'h360, 12'h364, 12'h368, 12'h36c};
    int                errors, checked, cyc;
    general_purpose_event_unit DUT (.mclk(mclk), .rstn(rstn), .warm_rst(warm_rst),
        .apb_req(req), .apb_rsp(rsp), .hp_event_req(hp), .inband_notify_en(ibn),
        .shared_event_out(shr), .gpio7_i(pin), .gpio7_drv(drv), .irq(irq));
    gpe_pin_host u_host (.mclk(mclk), .rstn(rstn), .drv(drv), .inv(inv), .pin(pin),
        .evt(evt));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        @(posedge mclk);
        while (rsp.pready !== 1'b1) @(posedge mclk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        xf(1'b0, a, 32'h0);
        `CHK("prdata", e, rd)
        `CHK("pslverr", ee, err)
    endtask
    // Hold new event levels long enough for the two-edge path to settle
    task ev(input logic [3:0] h);
        @(posedge mclk);
        hp <= h;
        repeat (3) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            final_report;
        end
    end
    initial begin
        rstn = 1'b0; warm_rst = 1'b0; req = '0; hp = 4'h0; inv = 1'b0;
        errors = 0; checked = 0; cyc = 0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(adr[i], (i == 4) ? 32'h8 : 32'h0, 1'b0);
        rchk(12'h358, 32'h0, 1'b1);
        xf(1'b1, 12'h370, 32'hffffffff);
        `CHK("wr_err", 1'b1, err)
        xf(1'b1, 12'h35c, 32'hffffffff);
        rchk(12'h35c, 32'h0000003d, 1'b0);
        xf(1'b1, 12'h35c, 32'h0);
        ev(4'hf);
        `CHK("shared", 1'b0, shr)
        `CHK("inband", 4'hf, ibn)
        rchk(12'h360, 32'h0, 1'b0);
        ev(4'h0);
        xf(1'b1, 12'h368, 32'h1e);
        xf(1'b1, 12'h36c, 32'h1);
        for (int i = 0; i < 4; i++) begin
            xf(1'b1, 12'h35c, (32'h4 << i) | (i & 1));
            inv = i[0];
            ev(4'hf);
            `CHK("inband", ~(4'h1 << i), ibn)
            `CHK("shared", 1'b1, shr)
            `CHK("pin", inv, pin)
            `CHK("evt", 1'b1, evt)
            `CHK("irq", 1'b1, irq)
            rchk(12'h360, 32'h2 << i, 1'b0);
            rchk(12'h364, 32'h2 << i, 1'b0);
            repeat (2) @(posedge mclk);
            `CHK("irq_clr", 1'b0, irq)
            ev(4'h0);
            `CHK("shared", 1'b0, shr)
            `CHK("pin", ~inv, pin)
        end
        xf(1'b1, 12'h368, 32'h0);
        xf(1'b1, 12'h35c, 32'h3c);
        inv = 1'b0;
        ev(4'h1);
        `CHK("irq_mask", 1'b0, irq)
        rchk(12'h364, 32'h2, 1'b0);
        xf(1'b1, 12'h360, 32'hffffffff);
        rchk(12'h360, 32'h2, 1'b0);
        xf(1'b1, 12'h36c, 32'h6);
        repeat (5) @(posedge mclk);
        `CHK("pin_gpio", 1'b1, pin)
        rchk(12'h36c, 32'he, 1'b0);
        xf(1'b1, 12'h36c, 32'h4);
        repeat (2) @(posedge mclk);
        `CHK("pin_gpio", 1'b0, pin)
        warm_rst <= 1'b1;
        @(posedge mclk);
        warm_rst <= 1'b0;
        rchk(12'h35c, 32'h3c, 1'b0);
        rchk(12'h368, 32'h0, 1'b0);
        `CHK("oe", 1'b0, drv.oe)
        final_report;
    end
endmodule
